// ===== rtl/buck_regulator_control_regs.sv
// Function
// - Mode bit 5: 0 off, 1 sleep
// - Mode bits 3:0 hold switching-mode code
// - Configuration at 0x24; bits 7,1 read zero
// - Bit 6 step rate: 2.0us or 4.0us
// - Bits 5:4 phase select, resets to zero
// - Bits 3:2 switching frequency select
// - Bit 0 current limit: 0 4.0A, 1 2.0A
// - Run voltage at 0x35, code bits 4:0
// - Run bit 5 selects low/high range
// - Standby voltage at 0x36, code bits 4:0
// - Standby has its own range bit 5
// - Variable fields load from OTP at reset
// - All registers read anytime; writes take effect except on the OTP load edge
// - Mode register decoded at 0x23
`timescale 1ns/100ps
module buck_regulator_control_regs
   import buck_regs_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   // Register access port from the serial control logic
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic dup_listing_access,
   // OTP-sourced reset images, static while the device runs
   input wire logic [7:0] otp_mode,
   input wire logic [7:0] otp_conf,
   input wire logic [7:0] otp_run,
   input wire logic [7:0] otp_stby,
   // Control fields to the regulators
   output logic buck_one_turnoff_behaviour,
   output logic [3:0] buck_one_switching_mode_code,
   output logic buck_one_step_rate,
   output logic [1:0] buck_one_phase_select,
   output logic [1:0] buck_one_frequency_select,
   output logic buck_one_current_limit,
   output logic buck_one_step_tick,
   output logic [4:0] buck_two_run_voltage_code,
   output logic buck_two_range_high,
   output logic [4:0] buck_two_standby_voltage_code,
   output logic buck_two_standby_range_high
);
   import buck_regs_pkg::*;

   // ----------------------------------------------------------------
   // OTP load sequencing
   // ----------------------------------------------------------------
   logic loaded_reg; // Set once the OTP image has been taken
   reg_access_if acc ();

   // One load pulse on the first edge after reset release
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         // Held in reset: the load is still owed
         loaded_reg <= 1'b0;
      end
      else
      begin
         // Stays set until the next reset
         loaded_reg <= 1'b1;
      end
   end

   assign acc.addr = reg_addr;
   assign acc.wdata = reg_wdata;
   assign acc.wr_en = reg_wr_en;
   assign acc.otp_load = !loaded_reg;
   // The OTP images are read only while otp_load is high; they share this
   // clock and sit still, so they need no synchroniser of their own

   // ----------------------------------------------------------------
   // Register slots
   // ----------------------------------------------------------------
   logic [7:0] buck1_mode_select;     // Turn-off behaviour and switching mode
   logic [7:0] buck1_configuration;   // Step rate, phase, frequency, limit
   logic [7:0] buck2_run_voltage;     // Normal-operation voltage and range
   logic [7:0] buck2_standby_voltage; // Standby voltage and range

   // Each slot decodes its own offset; the shared strobes arrive through acc.
   // Offset 0x32 has no slot on purpose, so writes there change nothing.
   // Mode register; turn-off bit resets to zero, mode code from OTP
   reg_slot #(.OFFSET(BUCK1_MODE_OFS), .IMPL_MASK(MODE_IMPL_MASK),
      .OTP_MASK(MODE_OTP_MASK)) u_mode (
      .acc(acc.slot),
      .mclk(mclk),
      .nrst(nrst),
      .otp_value(otp_mode),
      .value(buck1_mode_select)
   );

   // Configuration; phase bits are not in the OTP mask so reset to zero
   reg_slot #(.OFFSET(BUCK1_CONF_OFS), .IMPL_MASK(CONF_IMPL_MASK),
      .OTP_MASK(CONF_OTP_MASK)) u_conf (
      .acc(acc.slot),
      .mclk(mclk),
      .nrst(nrst),
      .otp_value(otp_conf),
      .value(buck1_configuration)
   );

   // Run voltage, code and range both OTP-loaded
   reg_slot #(.OFFSET(BUCK2_RUN_OFS), .IMPL_MASK(VOLT_IMPL_MASK),
      .OTP_MASK(VOLT_OTP_MASK)) u_run (
      .acc(acc.slot),
      .mclk(mclk),
      .nrst(nrst),
      .otp_value(otp_run),
      .value(buck2_run_voltage)
   );

   // Standby voltage keeps its own range bit
   reg_slot #(.OFFSET(BUCK2_STBY_OFS), .IMPL_MASK(VOLT_IMPL_MASK),
      .OTP_MASK(VOLT_OTP_MASK)) u_stby (
      .acc(acc.slot),
      .mclk(mclk),
      .nrst(nrst),
      .otp_value(otp_stby),
      .value(buck2_standby_voltage)
   );

   // ----------------------------------------------------------------
   // Field outputs
   // ----------------------------------------------------------------
   // Mode register fields
   assign buck_one_turnoff_behaviour = buck1_mode_select[TURNOFF_BIT];
   assign buck_one_switching_mode_code = buck1_mode_select[SWMODE_MSB:SWMODE_LSB];
   // Configuration fields; bits 7 and 1 hold no state
   assign buck_one_step_rate = buck1_configuration[STEP_RATE_BIT];
   assign buck_one_phase_select = buck1_configuration[PHASE_MSB:PHASE_LSB];
   assign buck_one_frequency_select = buck1_configuration[FREQ_MSB:FREQ_LSB];
   assign buck_one_current_limit = buck1_configuration[ILIM_BIT];
   // Regulator 2 run and standby fields, each with its own range bit
   assign buck_two_run_voltage_code = buck2_run_voltage[VCODE_MSB:VCODE_LSB];
   assign buck_two_range_high = buck2_run_voltage[RANGE_BIT];
   assign buck_two_standby_voltage_code = buck2_standby_voltage[VCODE_MSB:VCODE_LSB];
   assign buck_two_standby_range_high = buck2_standby_voltage[RANGE_BIT];

   // ----------------------------------------------------------------
   // Voltage step pacing
   // ----------------------------------------------------------------
   // The tick only paces the analog stepper and carries no data, so a rate
   // change that cuts one slot short costs at most one early step
   localparam int STEP_W = $clog2(STEP_SLOW_CYCLES);
   localparam logic [STEP_W-1:0] FAST_LAST = STEP_W'(STEP_FAST_CYCLES - 1);
   localparam logic [STEP_W-1:0] SLOW_LAST = STEP_W'(STEP_SLOW_CYCLES - 1);
   logic [STEP_W-1:0] step_cnt_reg;  // Cycles into the current step slot
   logic [STEP_W-1:0] step_cnt_next; // Next count
   logic step_tick_reg;              // One-cycle pulse per 25 mV step slot
   // A rate change takes effect at once; a longer count simply wraps early
   wire [STEP_W-1:0] step_last = buck_one_step_rate ? SLOW_LAST : FAST_LAST;
   wire step_wrap = (step_cnt_reg >= step_last);

   assign step_cnt_next = step_wrap ? '0 : step_cnt_reg + 1'b1;

   // Step slot counter and its tick
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         // Pacing restarts from the top of a slot
         step_cnt_reg <= '0;
         step_tick_reg <= 1'b0;
      end
      else
      begin
         // Free-running; the tick trails the wrap by one edge
         step_cnt_reg <= step_cnt_next;
         step_tick_reg <= step_wrap;
      end
   end

   assign buck_one_step_tick = step_tick_reg;

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [7:0] rdata_reg;  // Registered read data
   logic rvalid_reg;       // Read answer strobe
   logic dup_reg;          // Access to the undecoded duplicate offset
   // Read data is taken from the slot outputs, so a read in the same cycle
   // as a write to that offset returns the old contents
   wire [7:0] rd_mux =
      (reg_addr == BUCK1_MODE_OFS) ? buck1_mode_select :
      (reg_addr == BUCK1_CONF_OFS) ? buck1_configuration :
      (reg_addr == BUCK2_RUN_OFS) ? buck2_run_voltage :
      (reg_addr == BUCK2_STBY_OFS) ? buck2_standby_voltage :
      8'h00; // Unmapped offsets, 0x32 included, read as zero
   // Flagging 0x32 lets firmware written against the stale listing be caught
   wire dup_hit = (reg_wr_en || reg_rd_en) && (reg_addr == BUCK1_CONF_DUP_OFS);

   // Read answer one cycle after the strobe; never blocked
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         // No answer pending out of reset
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
         dup_reg <= 1'b0;
      end
      else
      begin
         // Read data holds between reads
         rdata_reg <= reg_rd_en ? rd_mux : rdata_reg;
         rvalid_reg <= reg_rd_en;
         dup_reg <= dup_hit;
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;
   assign dup_listing_access = dup_reg;

endmodule : buck_regulator_control_regs

// ===== rtl/buck_regs_pkg.sv
package buck_regs_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] BUCK1_MODE_OFS = 8'h23;
   localparam logic [7:0] BUCK1_CONF_OFS = 8'h24;
   // Second printed home of the configuration layout, deliberately not decoded
   localparam logic [7:0] BUCK1_CONF_DUP_OFS = 8'h32;
   localparam logic [7:0] BUCK2_RUN_OFS = 8'h35;
   localparam logic [7:0] BUCK2_STBY_OFS = 8'h36;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int TURNOFF_BIT = 5;
   localparam int SWMODE_MSB = 3;
   localparam int SWMODE_LSB = 0;
   localparam int STEP_RATE_BIT = 6;
   localparam int PHASE_MSB = 5;
   localparam int PHASE_LSB = 4;
   localparam int FREQ_MSB = 3;
   localparam int FREQ_LSB = 2;
   localparam int ILIM_BIT = 0;
   localparam int VCODE_MSB = 4;
   localparam int VCODE_LSB = 0;
   localparam int RANGE_BIT = 5;

   // ----------------------------------------------------------------
   // Implemented-bit masks and OTP-loaded-bit masks
   // ----------------------------------------------------------------
   localparam logic [7:0] MODE_IMPL_MASK = 8'h2f;
   localparam logic [7:0] MODE_OTP_MASK = 8'h0f;
   localparam logic [7:0] CONF_IMPL_MASK = 8'h7d;
   localparam logic [7:0] CONF_OTP_MASK = 8'h4d;
   localparam logic [7:0] VOLT_IMPL_MASK = 8'h3f;
   localparam logic [7:0] VOLT_OTP_MASK = 8'h3f;

   // Fixed reset value of every register before the OTP load
   localparam logic [7:0] REG_RESET_VALUE = 8'h00;

   // ----------------------------------------------------------------
   // Voltage step timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int STEP_FAST_PS = 2000000;
   localparam int STEP_SLOW_PS = 4000000;
   localparam int STEP_FAST_CYCLES = STEP_FAST_PS / CLK_PERIOD_PS;
   localparam int STEP_SLOW_CYCLES = STEP_SLOW_PS / CLK_PERIOD_PS;

endpackage : buck_regs_pkg

// ===== rtl/reg_access_if.sv
`timescale 1ns/100ps
// Write and load strobes shared by every register slot
interface reg_access_if;
   logic [7:0] addr;   // Register offset of the current access
   logic [7:0] wdata;  // Write data
   logic wr_en;        // One-cycle write strobe
   logic otp_load;     // One-cycle OTP load pulse after reset

   modport master (output addr, output wdata, output wr_en, output otp_load);
   modport slot (input addr, input wdata, input wr_en, input otp_load);
endinterface : reg_access_if

// ===== rtl/reg_slot.sv
`timescale 1ns/100ps
module reg_slot
   import buck_regs_pkg::*;
#(
   parameter logic [7:0] OFFSET = 8'h00,
   parameter logic [7:0] IMPL_MASK = 8'hff,
   parameter logic [7:0] OTP_MASK = 8'h00
)
(
   reg_access_if.slot acc,
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] otp_value,
   output logic [7:0] value
);
   import buck_regs_pkg::*;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic [7:0] value_reg;  // Stored register contents
   logic [7:0] value_next; // Next contents
   wire hit = (acc.addr == OFFSET);  // This slot is addressed
   wire do_write = acc.wr_en && hit; // Writes accepted at any time otp_load is low

   // OTP load wins; otherwise a write stores only implemented bits
   assign value_next = acc.otp_load ? (otp_value & OTP_MASK)
                     : do_write ? (acc.wdata & IMPL_MASK)
                     : value_reg;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Constant reset; OTP content arrives one edge after release
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         value_reg <= REG_RESET_VALUE;
      end
      else
      begin
         value_reg <= value_next;
      end
   end

   assign value = value_reg;

endmodule : reg_slot

// ===== verification/buck_regs_checker.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Port-level checks of the buck control register bank
// ----------------------------------------------------------------
module buck_regs_checker
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic dup_listing_access,
   input wire logic buck_one_turnoff_behaviour,
   input wire logic [3:0] buck_one_switching_mode_code,
   input wire logic buck_one_step_rate,
   input wire logic [1:0] buck_one_phase_select,
   input wire logic [1:0] buck_one_frequency_select,
   input wire logic buck_one_current_limit,
   input wire logic [4:0] buck_two_run_voltage_code,
   input wire logic buck_two_range_high,
   input wire logic [4:0] buck_two_standby_voltage_code,
   input wire logic buck_two_standby_range_high
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Any access to the second printed home of the configuration
   wire logic dup_hit = (reg_wr_en || reg_rd_en) && reg_addr == 8'h32;
   // Per-register write strobes
   wire logic wr_mode = reg_wr_en && reg_addr == 8'h23;
   wire logic wr_conf = reg_wr_en && reg_addr == 8'h24;
   wire logic wr_run = reg_wr_en && reg_addr == 8'h35;
   wire logic wr_stby = reg_wr_en && reg_addr == 8'h36;

   a_read_answer: assert property (reg_rd_en |=> reg_rvalid)
      else $error("read got no answer");
   a_rvalid_quiet: assert property (!reg_rd_en |=> !reg_rvalid)
      else $error("answer without read");
   a_dup_flag: assert property (dup_hit |=> dup_listing_access)
      else $error("duplicate access not flagged");
   a_dup_quiet: assert property (!dup_hit |=> !dup_listing_access)
      else $error("spurious duplicate flag");
   a_dup_reads_zero: assert property (reg_rd_en && reg_addr == 8'h32 |=> reg_rdata == 8'h00)
      else $error("duplicate offset not zero");
   a_mode_write: assert property (wr_mode |=> {buck_one_turnoff_behaviour,
      buck_one_switching_mode_code} == {$past(reg_wdata[5]), $past(reg_wdata[3:0])})
      else $error("mode fields wrong");
   a_conf_write: assert property (wr_conf |=> {buck_one_step_rate, buck_one_phase_select,
      buck_one_frequency_select, buck_one_current_limit} == {$past(reg_wdata[6:2]),
      $past(reg_wdata[0])})
      else $error("configuration fields wrong");
   a_run_write: assert property (wr_run |=> {buck_two_range_high,
      buck_two_run_voltage_code} == $past(reg_wdata[5:0]))
      else $error("run voltage fields wrong");
   a_stby_write: assert property (wr_stby |=> {buck_two_standby_range_high,
      buck_two_standby_voltage_code} == $past(reg_wdata[5:0]))
      else $error("standby voltage fields wrong");
endmodule : buck_regs_checker

// ===== verification/buck_regulator_control_regs_tb.sv
`timescale 1ns/100ps
module buck_regulator_control_regs_tb;
   logic mclk, nrst, reg_wr_en, reg_rd_en, reg_rvalid, dup_listing_access;
   logic buck_one_turnoff_behaviour, buck_one_step_rate, buck_one_current_limit;
   logic buck_one_step_tick, buck_two_range_high, buck_two_standby_range_high;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, otp_mode, otp_conf, otp_run, otp_stby;
   logic [3:0] buck_one_switching_mode_code;
   logic [1:0] buck_one_phase_select, buck_one_frequency_select;
   logic [4:0] buck_two_run_voltage_code, buck_two_standby_voltage_code;
   int n_errors, checks, cyc;
   // Offsets, OTP-loaded images and all-ones write images
   logic [7:0] ofs [4] = '{8'h23, 8'h24, 8'h35, 8'h36};
   logic [7:0] rst_img [4] = '{8'h0f, 8'h4d, 8'h3f, 8'h2a};
   logic [7:0] ff_img [4] = '{8'h2f, 8'h7d, 8'h3f, 8'h3f};

   buck_regulator_control_regs u_dut (.*);

   // ----------------------------------------------------------------
   // Clock and hang guard
   // ----------------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Whole run is a few thousand cycles; this ceiling only cuts a hang
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
         n_errors++;
      end
   endtask : chk
   // One strobe cycle, then one idle cycle so no strobe is set twice per step
   task automatic drive(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      reg_wr_en = w;
      reg_rd_en = !w;
      reg_addr = a;
      reg_wdata = d;
      @(posedge mclk);
      #1;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
   endtask : drive
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      drive(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      drive(1'b0, a, 8'h00);
      chk("rvalid", reg_rvalid, 1'b1);
      chk("rdata", reg_rdata, exp);
   endtask : rd
   // First gap only aligns to a tick; the second is measured
   task automatic tick_gap(input int exp);
      int n;
      n = 0;
      repeat (2)
      begin
         n = 0;
         do
         begin
            @(posedge mclk);
            #1;
            n++;
         end while (buck_one_step_tick !== 1'b1 && n < 2000);
      end
      chk("tick gap", n[15:0], exp[15:0]);
   endtask : tick_gap
   task give_verdict;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      nrst = 1'b0;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      otp_mode = 8'hff;
      otp_conf = 8'hff;
      otp_run = 8'hff;
      otp_stby = 8'hea;
      repeat (10) @(posedge mclk);
      #1;
      nrst = 1'b1;
      // OTP images land, fixed fields stay zero
      for (int i = 0; i < 4; i++) rd(ofs[i], rst_img[i]);
      chk("phase reset", buck_one_phase_select, 2'b00);
      chk("turnoff reset", buck_one_turnoff_behaviour, 1'b0);
      // Unimplemented bits drop on write and read zero
      for (int i = 0; i < 4; i++)
      begin
         wr(ofs[i], 8'hff);
         rd(ofs[i], ff_img[i]);
      end
      // Duplicate listing is flagged and not decoded
      wr(8'h32, 8'h00);
      chk("dup flag", dup_listing_access, 1'b1);
      rd(8'h32, 8'h00);
      rd(8'h24, 8'h7d);
      wr(8'h00, 8'hff);
      rd(8'h00, 8'h00);
      // Configuration field placement
      wr(8'h24, 8'h41);
      chk("conf a", {buck_one_step_rate, buck_one_phase_select, buck_one_frequency_select,
         buck_one_current_limit}, 6'b100001);
      wr(8'h24, 8'h2c);
      chk("conf b", {buck_one_step_rate, buck_one_phase_select, buck_one_frequency_select,
         buck_one_current_limit}, 6'b010110);
      // Every switching mode code, turn-off bit toggling alongside
      for (int c = 0; c < 16; c++)
      begin
         wr(8'h23, {2'b00, c[0], 1'b0, c[3:0]});
         chk("mode", {buck_one_turnoff_behaviour, buck_one_switching_mode_code},
            {c[0], c[3:0]});
      end
      // Run and standby keep separate range bits
      wr(8'h35, 8'h20);
      wr(8'h36, 8'h1f);
      chk("run", {buck_two_range_high, buck_two_run_voltage_code}, 6'h20);
      chk("stby", {buck_two_standby_range_high, buck_two_standby_voltage_code}, 6'h1f);
      rd(8'h35, 8'h20);
      rd(8'h36, 8'h1f);
      // Step pacing for both rates
      wr(8'h24, 8'h00);
      tick_gap(400);
      wr(8'h24, 8'h40);
      tick_gap(800);
      // Mid-run reset: outputs clear, then fresh OTP images reload
      @(posedge mclk);
      #1;
      nrst = 1'b0;
      otp_mode = 8'h3a;
      otp_conf = 8'hb6;
      otp_run = 8'hc9;
      otp_stby = 8'h15;
      repeat (3) @(posedge mclk);
      #1;
      chk("rst rdata", reg_rdata, 8'h00);
      chk("rst run", {buck_two_range_high, buck_two_run_voltage_code}, 6'h00);
      chk("rst tick", buck_one_step_tick, 1'b0);
      nrst = 1'b1;
      rd(8'h23, 8'h0a);
      rd(8'h24, 8'h04);
      rd(8'h35, 8'h09);
      rd(8'h36, 8'h15);
      chk("turnoff reload", buck_one_turnoff_behaviour, 1'b0);
      chk("phase reload", buck_one_phase_select, 2'b00);
      give_verdict();
   end
endmodule : buck_regulator_control_regs_tb

bind buck_regulator_control_regs buck_regs_checker u_chk (.*);
